// ### itb_timer_regs.vh
`ifndef ITB_TIMER_REGS_VH
`define ITB_TIMER_REGS_VH

// Register addresses on the plain register port.
`define ITB_ADDR_W 2
`define ITB_ADDR_MODE 2'h0
`define ITB_ADDR_COUNT 2'h1
`define ITB_ADDR_IRQ_PORT 2'h2

// Field positions of timer_mode_control.
`define ITB_MODE_OCS_HI 7
`define ITB_MODE_OCS_LO 5
`define ITB_MODE_RSV_BIT 4
`define ITB_MODE_MS_BIT 3
`define ITB_MODE_RATE_HI 2
`define ITB_MODE_RATE_LO 0

// Field positions of the interrupt and port control register.
`define ITB_CTL_FLAG_BIT 0
`define ITB_CTL_IEN_BIT 1
`define ITB_CTL_PIN_BIT 2

// Reset values.
`define ITB_MODE_RESET 8'h00
`define ITB_COUNT_RESET 8'h00
`define ITB_RSV_READ 1'b1

// Prescaler widths.
`define ITB_PSS_W 13
`define ITB_PSW_W 7

// Interval divisors, as the base-two logarithm of the system clock division.
`define ITB_LOG_DIV8192 4'hD
`define ITB_LOG_DIV4096 4'hC
`define ITB_LOG_DIV2048 4'hB
`define ITB_LOG_DIV512 4'h9
`define ITB_LOG_DIV256 4'h8
`define ITB_LOG_DIV128 4'h7
`define ITB_LOG_DIV32 4'h5
`define ITB_LOG_DIV8 4'h3

// Time base: sub-clock rate and overflow periods in microseconds.
`define ITB_SUB_HZ 32768
`define ITB_PERIOD_1S_US 1000000
`define ITB_PERIOD_HALF_US 500000
`define ITB_PERIOD_QUARTER_US 250000
`define ITB_PERIOD_32TH_US 31250
// Watch prescaler division per count = period * rate / (256 * 1e6), as log2.
`define ITB_LOG_TB_1S 3'h7
`define ITB_LOG_TB_HALF 3'h6
`define ITB_LOG_TB_QUARTER 3'h5
`define ITB_LOG_TB_32TH 3'h2

`endif

// ### itb_sync.v
module itb_sync (
  input wire sys_clk_i,
  input wire resetn_i,
  input wire async_i,
  output wire level_o,
  output wire rise_o
);

  reg meta_reg;
  reg stable_reg;
  reg prev_reg;

  // Two flip-flops bring the pin into the system clock domain.
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      meta_reg <= 1'b0;
      stable_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= async_i;
      stable_reg <= meta_reg;
      prev_reg <= stable_reg;
    end
  end

  assign level_o = stable_reg;
  assign rise_o = stable_reg & ~prev_reg;

endmodule // itb_sync

// ### itb_timer.v
// Local design decisions: the address map and the plain strobed port.
`include "itb_timer_regs.vh"

module itb_timer (
  input wire sys_clk_i,
  input wire resetn_i,
  input wire sub_clk_i,
  input wire subactive_i,
  input wire [`ITB_ADDR_W-1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  output reg irq_o,
  output reg overflow_request_flag_o,
  output reg divided_clock_pin_o
);

  reg [2:0] output_clock_select_reg;
  reg mode_select_bit_reg;
  reg [2:0] rate_select_reg;
  reg [7:0] timer_count_value_reg;
  reg [7:0] timer_count_value_next;
  reg overflow_request_flag_next;
  reg overflow_interrupt_enable_reg;
  reg port_mode_pin_reg;
  reg [`ITB_PSS_W-1:0] sys_prescaler_reg;
  reg [`ITB_PSW_W-1:0] watch_prescaler_reg;
  reg [7:0] rdata_next;
  reg divclk_next;
  reg count_tick;
  reg overflow;

  wire sub_rise;
  wire [3:0] interval_log;
  wire [2:0] base_log;
  wire [`ITB_PSS_W-1:0] watch_wide;
  wire interval_tick;
  wire base_tick;
  wire tb_hold;
  wire wr_mode;
  wire wr_ctl;

  // Picks the interval divisor for a rate code.
  function [3:0] itb_interval_log;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: itb_interval_log = `ITB_LOG_DIV8192;
        3'h1: itb_interval_log = `ITB_LOG_DIV4096;
        3'h2: itb_interval_log = `ITB_LOG_DIV2048;
        3'h3: itb_interval_log = `ITB_LOG_DIV512;
        3'h4: itb_interval_log = `ITB_LOG_DIV256;
        3'h5: itb_interval_log = `ITB_LOG_DIV128;
        3'h6: itb_interval_log = `ITB_LOG_DIV32;
        3'h7: itb_interval_log = `ITB_LOG_DIV8;
        default: itb_interval_log = `ITB_LOG_DIV8192;
      endcase
    end
  endfunction

  // Picks the watch prescaler divisor for a time base period code.
  function [2:0] itb_base_log;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: itb_base_log = `ITB_LOG_TB_1S;
        2'h1: itb_base_log = `ITB_LOG_TB_HALF;
        2'h2: itb_base_log = `ITB_LOG_TB_QUARTER;
        2'h3: itb_base_log = `ITB_LOG_TB_32TH;
        default: itb_base_log = `ITB_LOG_TB_1S;
      endcase
    end
  endfunction

  // True when the low bits of a prescaler are all ones, so its next step
  // completes one period of the chosen division.
  function itb_all_ones;
    input [`ITB_PSS_W-1:0] value;
    input [3:0] log_div;
    reg [`ITB_PSS_W-1:0] mask;
    begin
      mask = ~({`ITB_PSS_W{1'b1}} << log_div);
      itb_all_ones = ((value & mask) == mask);
    end
  endfunction

  itb_sync u_sub_sync (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .async_i(sub_clk_i),
    .level_o(),
    .rise_o(sub_rise)
  );

  assign tb_hold = mode_select_bit_reg & rate_select_reg[2];
  assign wr_mode = wr_i && (addr_i == `ITB_ADDR_MODE);
  assign wr_ctl = wr_i && (addr_i == `ITB_ADDR_IRQ_PORT);

  // Mode register and the interrupt and port control bits.
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      output_clock_select_reg <= 3'h0;
      mode_select_bit_reg <= 1'b0;
      rate_select_reg <= 3'h0;
      overflow_interrupt_enable_reg <= 1'b0;
      port_mode_pin_reg <= 1'b0;
    end else begin
      if (wr_mode) begin
        output_clock_select_reg <= wdata_i[`ITB_MODE_OCS_HI:`ITB_MODE_OCS_LO];
        mode_select_bit_reg <= wdata_i[`ITB_MODE_MS_BIT];
        rate_select_reg <= wdata_i[`ITB_MODE_RATE_HI:`ITB_MODE_RATE_LO];
      end
      if (wr_ctl) begin
        overflow_interrupt_enable_reg <= wdata_i[`ITB_CTL_IEN_BIT];
        port_mode_pin_reg <= wdata_i[`ITB_CTL_PIN_BIT];
      end
    end
  end

  // System prescaler runs freely except in subactive mode.
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      sys_prescaler_reg <= {`ITB_PSS_W{1'b0}};
    end else if (!subactive_i) begin
      sys_prescaler_reg <= sys_prescaler_reg + 1'b1;
    end
  end

  // Watch prescaler steps on each synchronised sub-clock rising edge and clears while the time base is held.
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      watch_prescaler_reg <= {`ITB_PSW_W{1'b0}};
    end else if (tb_hold) begin
      watch_prescaler_reg <= {`ITB_PSW_W{1'b0}};
    end else if (sub_rise) begin
      watch_prescaler_reg <= watch_prescaler_reg + 1'b1;
    end
  end

  // Tap positions for the two counting modes.
  assign interval_log = itb_interval_log(rate_select_reg);
  assign base_log = itb_base_log(rate_select_reg[1:0]);
  assign watch_wide = {{(`ITB_PSS_W-`ITB_PSW_W){1'b0}}, watch_prescaler_reg};

  // The system tap stops with the system clock in subactive mode.
  assign interval_tick = !subactive_i && itb_all_ones(sys_prescaler_reg, interval_log);
  // The watch tap only counts while the time base is not held.
  assign base_tick = sub_rise && !rate_select_reg[2] &&
    itb_all_ones(watch_wide, {1'b0, base_log});

  // Counter tick selection.
  always @* begin
    count_tick = 1'b0;
    if (mode_select_bit_reg) begin
      count_tick = base_tick;
    end else begin
      count_tick = interval_tick;
    end
  end

  // Counter and overflow.
  always @* begin
    overflow = 1'b0;
    timer_count_value_next = timer_count_value_reg;
    if (tb_hold) begin
      timer_count_value_next = `ITB_COUNT_RESET;
    end else if (count_tick) begin
      timer_count_value_next = timer_count_value_reg + 8'h01;
      overflow = (timer_count_value_reg == 8'hFF);
    end
  end

  // The flag is cleared by writing zero to it; an overflow in the same cycle wins.
  always @* begin
    overflow_request_flag_next = overflow_request_flag_o;
    if (wr_ctl && !wdata_i[`ITB_CTL_FLAG_BIT]) begin
      overflow_request_flag_next = 1'b0;
    end
    if (overflow) begin
      overflow_request_flag_next = 1'b1;
    end
  end

  // Count register.
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      timer_count_value_reg <= `ITB_COUNT_RESET;
    end else begin
      timer_count_value_reg <= timer_count_value_next;
    end
  end

  // Overflow request flag.
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      overflow_request_flag_o <= 1'b0;
    end else begin
      overflow_request_flag_o <= overflow_request_flag_next;
    end
  end

  // Interrupt request follows the next flag value, gated by the enable.
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= overflow_request_flag_next & overflow_interrupt_enable_reg;
    end
  end

  // Divided clock pin source.
  always @* begin
    divclk_next = 1'b0;
    case (output_clock_select_reg)
      3'h0: divclk_next = sys_prescaler_reg[4];
      3'h1: divclk_next = sys_prescaler_reg[3];
      3'h2: divclk_next = sys_prescaler_reg[2];
      3'h3: divclk_next = sys_prescaler_reg[1];
      3'h4: divclk_next = watch_prescaler_reg[4];
      3'h5: divclk_next = watch_prescaler_reg[3];
      3'h6: divclk_next = watch_prescaler_reg[2];
      3'h7: divclk_next = watch_prescaler_reg[1];
      default: divclk_next = 1'b0;
    endcase
    if (subactive_i && !output_clock_select_reg[2]) begin
      divclk_next = 1'b0;
    end
    if (!port_mode_pin_reg) begin
      divclk_next = 1'b0;
    end
  end

  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      divided_clock_pin_o <= 1'b0;
    end else begin
      divided_clock_pin_o <= divclk_next;
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always @* begin
    rdata_next = 8'h00;
    if (rd_i) begin
      case (addr_i)
        `ITB_ADDR_MODE: begin
          rdata_next = {output_clock_select_reg, `ITB_RSV_READ, mode_select_bit_reg,
            rate_select_reg};
        end
        `ITB_ADDR_COUNT: begin
          rdata_next = subactive_i ? 8'h00 : timer_count_value_reg;
        end
        `ITB_ADDR_IRQ_PORT: begin
          rdata_next = {5'h00, port_mode_pin_reg, overflow_interrupt_enable_reg,
            overflow_request_flag_o};
        end
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rdata_next;
    end
  end

endmodule // itb_timer

// ### itb_timer_props.sv
`include "itb_timer_regs.vh"
module itb_timer_props (
  input wire sys_clk_i,
  input wire resetn_i,
  input wire subactive_i,
  input wire [`ITB_ADDR_W-1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire irq_o,
  input wire overflow_request_flag_o,
  input wire divided_clock_pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  reg ien_reg, pin_reg;
  reg [7:0] mode_reg;
  wire ctl_wr = wr_i && addr_i == `ITB_ADDR_IRQ_PORT;
  // Shadow copies of the control bits that the outputs depend on.
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      ien_reg <= 1'b0;
      pin_reg <= 1'b0;
      mode_reg <= 8'h00;
    end else begin
      if (ctl_wr) begin
        ien_reg <= wdata_i[1];
        pin_reg <= wdata_i[2];
      end
      if (wr_i && addr_i == `ITB_ADDR_MODE) mode_reg <= wdata_i;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not idle");
  a_rsv_bit: assert property (rd_i && addr_i == `ITB_ADDR_MODE |=> rdata_o[4])
    else $error("reserved bit not one");
  a_irq_flag: assert property (irq_o |-> overflow_request_flag_o)
    else $error("irq without flag");
  a_irq_enable: assert property (irq_o |-> ien_reg || $past(ien_reg))
    else $error("irq while disabled");
  a_flag_sticky: assert property (overflow_request_flag_o && !(ctl_wr && !wdata_i[0])
    |=> overflow_request_flag_o) else $error("flag lost");
  a_count_hold: assert property (rd_i && addr_i == `ITB_ADDR_COUNT &&
    mode_reg[3:2] == 2'b11 && $past(mode_reg[3:2]) == 2'b11 |=> rdata_o == 8'h00)
    else $error("count not held");
  a_sub_read: assert property (rd_i && addr_i == `ITB_ADDR_COUNT && subactive_i
    |=> rdata_o == 8'h00) else $error("count read in subactive");
  a_pin_off: assert property (!$past(pin_reg) |-> !divided_clock_pin_o)
    else $error("pin active while off");
  a_pin_sub: assert property ($past(subactive_i) && !$past(mode_reg[7]) |->
    !divided_clock_pin_o)
    else $error("system clock on pin in subactive");
  c_flag: cover property ($rose(overflow_request_flag_o));
  c_irq: cover property ($rose(irq_o));
  c_pin: cover property ($rose(divided_clock_pin_o));
endmodule // itb_timer_props

// ### tb_itb_timer.sv
`include "itb_timer_regs.vh"
module tb_itb_timer;
  timeunit 1ns;
  timeprecision 1ps;
  reg sys_clk_i = 0, resetn_i = 0, sub_clk_i = 0, subactive_i = 0, wr_i = 0, rd_i = 0;
  reg [`ITB_ADDR_W-1:0] addr_i = 0;
  reg [7:0] wdata_i = 0, a, b;
  wire [7:0] rdata_o;
  wire irq_o, overflow_request_flag_o, divided_clock_pin_o;
  integer mismatches = 0, checks_done = 0, i, n;
  localparam int LOGN[8] = '{13, 12, 11, 9, 8, 7, 5, 3};
  itb_timer u_itb_timer (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .sub_clk_i(sub_clk_i),
    .subactive_i(subactive_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .irq_o(irq_o), .overflow_request_flag_o(overflow_request_flag_o),
    .divided_clock_pin_o(divided_clock_pin_o));
  initial forever #20 sys_clk_i = ~sys_clk_i;
  initial forever #15259 sub_clk_i = ~sub_clk_i;
  task results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string s, input [7:0] e, input [7:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task cyc(input integer c);
    repeat (c) @(posedge sys_clk_i);
  endtask
  task wr(input [1:0] ad, input [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= ad; wdata_i <= d; wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task rd(input [1:0] ad, output [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= ad; rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task rises(input integer c, output integer r);
    reg p;
    r = 0;
    cyc(2);
    #1 p = divided_clock_pin_o;
    repeat (c) begin
      @(posedge sys_clk_i);
      #1 if (divided_clock_pin_o && !p) r++;
      p = divided_clock_pin_o;
    end
  endtask
  task wait_flag;
    n = 0;
    while (overflow_request_flag_o !== 1'b1 && n < 2100) begin
      @(posedge sys_clk_i);
      #1 n++;
    end
  endtask
  initial begin
    cyc(16);
    resetn_i <= 1'b1;
    rd(0, a); chk("mode", 8'h10, a);
    rd(3, a); chk("unmapped", 8'h00, a);
    wr(3, 8'hFF); wr(1, 8'h55);
    rd(1, a); chk("count", 8'h00, a);
    for (i = 0; i < 8; i++) begin
      wr(0, i[7:0]);
      rd(1, a); cyc((1 << LOGN[i]) - 3); rd(1, b);
      chk("rate step", 8'h01, b - a);
    end
    wr(2, 8'h02);
    wait_flag;
    rd(1, a); chk("wrap", 8'h00, a);
    chk("flag", 8'h01, overflow_request_flag_o);
    chk("irq", 8'h01, irq_o);
    wr(2, 8'h00); chk("irq clr", 8'h00, irq_o);
    wait_flag;
    chk("flag2", 8'h01, overflow_request_flag_o);
    chk("irq off", 8'h00, irq_o);
    wr(2, 8'h00);
    wr(0, 8'h0C); rd(1, a); chk("hold", 8'h00, a);
    cyc(3100); rd(1, a); chk("hold2", 8'h00, a);
    wr(0, 8'h0B); #(10 * 30518);
    rd(1, a); chk("time base", 8'h02, a);
    @(posedge sys_clk_i) subactive_i <= 1'b1;
    rd(1, a); chk("sub read", 8'h00, a);
    @(posedge sys_clk_i) subactive_i <= 1'b0;
    wr(2, 8'h04);
    for (i = 0; i < 4; i++) begin
      wr(0, {i[2:0], 5'h07}); rises(64, n);
      chk("pin", 8'h02 << i, n[7:0]);
    end
    wr(0, 8'hE7);
    @(posedge sys_clk_i) subactive_i <= 1'b1;
    rises(6104, n); chk("pin sub", 8'h02, n[7:0]);
    wr(0, 8'h67); rises(64, n); chk("pin sys sub", 8'h00, n[7:0]);
    @(posedge sys_clk_i) subactive_i <= 1'b0;
    wr(2, 8'h00); rises(64, n); chk("pin off", 8'h00, n[7:0]);
    results;
  end
  initial begin
    #(90000 * 40);
    mismatches++;
    results;
  end
endmodule // tb_itb_timer
bind itb_timer itb_timer_props u_itb_timer_props (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
  .subactive_i(subactive_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .irq_o(irq_o), .overflow_request_flag_o(overflow_request_flag_o),
  .divided_clock_pin_o(divided_clock_pin_o));
